/* File: rtl/irc_remote_ctrl.v */
// Remote command handler: panel modes, display, trigger, calibration sequencer, status summary
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "irc_defines.vh"
module irc_remote_ctrl
#(
  parameter [15:0] CAL_PASSWORD = 16'h1234, // Arbitrary model password
  parameter [31:0] SEC_CYCLES   = `IRC_SEC_CYCLES,
  parameter [31:0] BEEP_CYCLES  = `IRC_BEEP_CYCLES
)
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Device events and status
  input  wire        bus_get_i,
  input  wire        local_key_i,
  input  wire [7:0]  status_bits_i,
  // Panel side
  output reg         knobs_enable,
  output reg         local_key_enable,
  output reg         display_on,
  output reg         annunciators_enable,
  output reg         error_annunciator_enable,
  output reg  [2:0]  panel_brightness,
  output reg         beeper_out,
  // Output stage
  output reg         output_update,
  output reg  [31:0] output_level,
  // Calibration
  output reg         cal_mode,
  output reg  [1:0]  cal_type,
  output reg         cal_point_strobe,
  output reg  [1:0]  cal_point_index,
  output reg  [31:0] cal_point_value,
  output reg         cal_prot_strobe,
  output reg         cal_store,
  // Service request
  output reg         service_request
);

  // Cal sequencer states
  localparam [1:0] CS_IDLE = 2'h0;
  localparam [1:0] CS_MID  = 2'h1;
  localparam [1:0] CS_MAX  = 2'h2;
  localparam [1:0] CS_DONE = 2'h3;

  // Byte-lane merge used by the control, trigger level and calibration value registers
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // Bus decode
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_we_i;
  wire        text_sel  = (wb_adr_i[7:5] == 3'h1);
  wire        cmd_wr    = bus_wr & (wb_adr_i == `IRC_OFS_COMMAND) & wb_sel_i[0];
  wire [3:0]  cmd_code  = wb_dat_i[3:0];
  wire [15:0] cmd_arg   = wb_dat_i[31:16];

  reg  [31:0] ctrl_r;
  reg  [11:0] delay_s_r;
  reg  [31:0] cal_val_r;
  reg  [31:0] trig_lvl_r;
  reg  [7:0]  stat_en_r;
  reg  [7:0]  srq_en_r;
  reg  [1:0]  mode_r;
  reg         text_valid_r;
  reg         armed_r;
  reg         delay_run_r;
  reg  [11:0] delay_left_r;
  reg  [31:0] sec_cnt_r;
  reg  [31:0] beep_cnt_r;
  reg  [1:0]  cs_r;
  reg         rd_text_r;
  wire [31:0] text_rdata;

  // Message store
  irc_text_mem u_text
  (
    .ref_clk (ref_clk),
    .wr_en   (bus_wr & text_sel),
    .wr_addr (wb_adr_i[4:2]),
    .wr_data (wb_dat_i),
    .rd_addr (wb_adr_i[4:2]),
    .rd_data (text_rdata)
  );

  // Read mux; text words go through the memory register so they answer a cycle later
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `IRC_OFS_VERSION:    rd_mux = {`IRC_VERSION_YEAR, `IRC_VERSION_FRAC};
      `IRC_OFS_CONTROL:    rd_mux = {ctrl_r[31:7], 7'h00} | {25'h0, panel_brightness, 1'b0,
                                    ctrl_r[`IRC_CTL_SRC_BUS], display_on,
                                    ctrl_r[`IRC_CTL_BEEPER]};
      `IRC_OFS_TRIG_DELAY: rd_mux = {20'h0, delay_s_r};
      `IRC_OFS_CAL_POINT:  rd_mux = {24'h0, cs_r, cal_type, 1'b0, text_valid_r, mode_r};
      `IRC_OFS_STATUS:     rd_mux = {16'h0, status_bits_i, 4'h0, armed_r, delay_run_r, cal_mode,
                                    service_request};
      `IRC_OFS_STAT_EN:    rd_mux = {24'h0, stat_en_r};
      `IRC_OFS_SRQ_EN:     rd_mux = {24'h0, srq_en_r};
      `IRC_OFS_TRIG_LEVEL: rd_mux = trig_lvl_r;
      `IRC_OFS_CAL_VALUE:  rd_mux = cal_val_r;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Wishbone answer: one wait cycle for text reads, single cycle otherwise
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      rd_text_r <= 1'b0;
    end
    else
    begin
      wb_ack_o  <= 1'b0;
      rd_text_r <= 1'b0;
      if (rd_text_r)
      begin
        wb_ack_o <= 1'b1;
        wb_dat_o <= text_valid_r ? text_rdata : 32'h0000_0000;
      end
      else if (bus_req && text_sel && !wb_we_i)
        rd_text_r <= 1'b1;
      else if (bus_req)
      begin
        wb_ack_o <= 1'b1;
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Configuration registers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r     <= `IRC_CTL_RESET;
      delay_s_r  <= 12'h000;
      trig_lvl_r <= 32'h0000_0000;
      cal_val_r  <= 32'h0000_0000;
      stat_en_r  <= 8'h00;
      srq_en_r   <= 8'h00;
    end
    else if (bus_wr && !rd_text_r)
    begin
      case (wb_adr_i)
        `IRC_OFS_CONTROL:    ctrl_r <= lane_merge(ctrl_r, wb_dat_i, wb_sel_i);
        `IRC_OFS_TRIG_DELAY:
          if (wb_sel_i[0] && wb_sel_i[1])
            delay_s_r <= (wb_dat_i[31:0] > {20'h0, `IRC_DELAY_MAX_S}) ?
                         `IRC_DELAY_MAX_S : wb_dat_i[11:0];
        `IRC_OFS_TRIG_LEVEL: trig_lvl_r <= lane_merge(trig_lvl_r, wb_dat_i, wb_sel_i);
        `IRC_OFS_CAL_VALUE:  cal_val_r <= lane_merge(cal_val_r, wb_dat_i, wb_sel_i);
        `IRC_OFS_STAT_EN:    if (wb_sel_i[0]) stat_en_r <= wb_dat_i[7:0];
        `IRC_OFS_SRQ_EN:     if (wb_sel_i[0]) srq_en_r <= wb_dat_i[7:0];
        default:             ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Panel mode, display, text and beeper
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r                   <= `IRC_MODE_LOCAL;
      display_on               <= 1'b1;
      text_valid_r             <= 1'b0;
      knobs_enable             <= 1'b1;
      local_key_enable         <= 1'b1;
      annunciators_enable      <= 1'b1;
      error_annunciator_enable <= 1'b1;
      panel_brightness         <= `IRC_BRIGHT_MAX;
      beeper_out               <= 1'b0;
      beep_cnt_r               <= 32'h0000_0000;
    end
    else
    begin
      // Local key only honoured in remote mode
      if ((cmd_wr && cmd_code == `IRC_CMD_LOCAL) || (local_key_i && mode_r == `IRC_MODE_REMOTE))
      begin
        mode_r              <= `IRC_MODE_LOCAL;
        display_on          <= 1'b1;
        annunciators_enable <= 1'b1;
      end
      else if (cmd_wr && cmd_code == `IRC_CMD_REMOTE)
        mode_r <= `IRC_MODE_REMOTE;
      else if (cmd_wr && cmd_code == `IRC_CMD_LOCKOUT)
        mode_r <= `IRC_MODE_LOCKOUT;
      // Annunciators move in the same cycle as the display, so none but the error annunciator glows while blank
      else if (bus_wr && wb_adr_i == `IRC_OFS_CONTROL && wb_sel_i[0])
      begin
        display_on          <= wb_dat_i[`IRC_CTL_DISPLAY];
        annunciators_enable <= wb_dat_i[`IRC_CTL_DISPLAY];
      end
      knobs_enable        <= (mode_r == `IRC_MODE_LOCAL);
      local_key_enable    <= (mode_r != `IRC_MODE_LOCKOUT);
      error_annunciator_enable <= 1'b1;
      // Brightness above 4 is refused, older value kept
      if (ctrl_r[`IRC_CTL_BRIGHT_LSB +: 3] <= `IRC_BRIGHT_MAX)
        panel_brightness <= ctrl_r[`IRC_CTL_BRIGHT_LSB +: 3];
      if (bus_wr && text_sel)
        text_valid_r <= 1'b1;
      else if (cmd_wr && cmd_code == `IRC_CMD_TEXT_CLR)
        text_valid_r <= 1'b0;
      // One fixed-length beep, only when the beeper is enabled
      if (cmd_wr && cmd_code == `IRC_CMD_BEEP && ctrl_r[`IRC_CTL_BEEPER])
        beep_cnt_r <= BEEP_CYCLES;
      else if (beep_cnt_r != 32'h0000_0000)
        beep_cnt_r <= beep_cnt_r - 32'h0000_0001;
      beeper_out <= (beep_cnt_r != 32'h0000_0000);
    end
  end

  // Trigger system: arm, immediate fire or bus trigger with delay
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      armed_r       <= 1'b0;
      delay_run_r   <= 1'b0;
      delay_left_r  <= 12'h000;
      sec_cnt_r     <= 32'h0000_0000;
      output_update <= 1'b0;
      output_level  <= 32'h0000_0000;
    end
    else
    begin
      output_update <= 1'b0;
      if (cmd_wr && cmd_code == `IRC_CMD_ARM)
      begin
        if (!ctrl_r[`IRC_CTL_SRC_BUS])
        begin
          output_update <= 1'b1;
          output_level  <= trig_lvl_r;
          armed_r       <= 1'b0;
        end
        else
          armed_r <= 1'b1;
      end
      else if (armed_r && (bus_get_i || (cmd_wr && cmd_code == `IRC_CMD_TRG)))
      begin
        armed_r      <= 1'b0;
        delay_run_r  <= 1'b1;
        delay_left_r <= delay_s_r;
        sec_cnt_r    <= SEC_CYCLES - 32'h0000_0001;
      end
      else if (delay_run_r)
      begin
        if (delay_left_r == 12'h000)
        begin
          delay_run_r   <= 1'b0;
          output_update <= 1'b1;
          output_level  <= trig_lvl_r;
        end
        else if (sec_cnt_r == 32'h0000_0000)
        begin
          delay_left_r <= delay_left_r - 12'h001;
          sec_cnt_r    <= SEC_CYCLES - 32'h0000_0001;
        end
        else
          sec_cnt_r <= sec_cnt_r - 32'h0000_0001;
      end
    end
  end

  // Calibration sequencer
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cal_mode         <= 1'b0;
      cal_type         <= `IRC_CAL_VOLT;
      cs_r             <= CS_IDLE;
      cal_point_strobe <= 1'b0;
      cal_point_index  <= 2'h0;
      cal_point_value  <= 32'h0000_0000;
      cal_prot_strobe  <= 1'b0;
      cal_store        <= 1'b0;
    end
    else
    begin
      cal_point_strobe <= 1'b0;
      cal_prot_strobe  <= 1'b0;
      cal_store        <= 1'b0;
      if (cmd_wr && cmd_code == `IRC_CMD_CAL_PASS && !cal_mode)
      begin
        if (cmd_arg == CAL_PASSWORD)
        begin
          cal_mode <= 1'b1;
          cs_r     <= CS_IDLE;
        end
      end
      else if (cmd_wr && cal_mode)
      begin
        case (cmd_code)
          `IRC_CMD_CAL_TYPE:
          begin
            cal_type <= cmd_arg[1:0];
            cs_r     <= CS_IDLE;
          end
          `IRC_CMD_CAL_MIN, `IRC_CMD_CAL_MID, `IRC_CMD_CAL_MAX:
          begin
            cal_point_strobe <= 1'b1;
            cal_point_index  <= cmd_code[1:0] - 2'h2;
            cal_point_value  <= cal_val_r;
            case (cs_r)
              CS_IDLE: cs_r <= (cmd_code == `IRC_CMD_CAL_MIN) ? CS_MID : CS_IDLE;
              CS_MID:  cs_r <= (cmd_code == `IRC_CMD_CAL_MID) ? CS_MAX : CS_IDLE;
              CS_MAX:
                if (cmd_code == `IRC_CMD_CAL_MAX)
                begin
                  cs_r     <= CS_DONE;
                  cal_type <= cal_type | 2'h1;
                end
                else
                  cs_r <= CS_IDLE;
              default: cs_r <= CS_IDLE;
            endcase
          end
          `IRC_CMD_CAL_PROT:
          begin
            cal_prot_strobe <= 1'b1;
            cs_r            <= CS_IDLE;
          end
          `IRC_CMD_CAL_SAVE:
          begin
            cal_store <= 1'b1;
            cal_mode  <= 1'b0;
            cs_r      <= CS_IDLE;
          end
          `IRC_CMD_CAL_END:
          begin
            cal_mode <= 1'b0;
            cs_r     <= CS_IDLE;
          end
          default: cs_r <= cs_r;
        endcase
      end
    end
  end

  // Summary and service request as the last reporting step
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      service_request <= 1'b0;
    else
      service_request <= |(status_bits_i & stat_en_r & srq_en_r);
  end

endmodule

/* File: rtl/irc_defines.vh */
// Register offsets, field positions, reset values and timing counts of the remote-control block
`ifndef IRC_DEFINES_VH
`define IRC_DEFINES_VH

// Word offsets (byte addresses)
`define IRC_OFS_VERSION    8'h00
`define IRC_OFS_COMMAND    8'h04
`define IRC_OFS_CONTROL    8'h08
`define IRC_OFS_TRIG_DELAY 8'h0C
`define IRC_OFS_CAL_POINT  8'h10
`define IRC_OFS_STATUS     8'h14
`define IRC_OFS_TEXT_BASE  8'h20
`define IRC_OFS_STAT_EN    8'h18
`define IRC_OFS_SRQ_EN     8'h1C
`define IRC_OFS_TRIG_LEVEL 8'h40
`define IRC_OFS_CAL_VALUE  8'h44

// Fixed language version 1994.0 as integer year and fraction
`define IRC_VERSION_YEAR   16'h07CA
`define IRC_VERSION_FRAC   16'h0000

// Command codes written to the command register
`define IRC_CMD_BEEP       4'h1
`define IRC_CMD_LOCAL      4'h2
`define IRC_CMD_REMOTE     4'h3
`define IRC_CMD_LOCKOUT    4'h4
`define IRC_CMD_TEXT_CLR   4'h5
`define IRC_CMD_ARM        4'h6
`define IRC_CMD_TRG        4'h7
`define IRC_CMD_CAL_PASS   4'h8
`define IRC_CMD_CAL_TYPE   4'h9
`define IRC_CMD_CAL_MIN    4'hA
`define IRC_CMD_CAL_MID    4'hB
`define IRC_CMD_CAL_MAX    4'hC
`define IRC_CMD_CAL_PROT   4'hD
`define IRC_CMD_CAL_SAVE   4'hE
`define IRC_CMD_CAL_END    4'hF

// Control register field positions
`define IRC_CTL_BEEPER     0
`define IRC_CTL_DISPLAY    1
`define IRC_CTL_SRC_BUS    2
`define IRC_CTL_BRIGHT_LSB 4
`define IRC_CTL_RESET      32'h0000_0042

// Panel modes
`define IRC_MODE_LOCAL     2'h0
`define IRC_MODE_REMOTE    2'h1
`define IRC_MODE_LOCKOUT   2'h2

// Calibration types
`define IRC_CAL_VOLT       2'h0
`define IRC_CAL_OVP        2'h1
`define IRC_CAL_CURR       2'h2
`define IRC_CAL_OCP        2'h3

// Limits
`define IRC_BRIGHT_MAX     3'h4
`define IRC_DELAY_MAX_S    12'hE10
`define IRC_CLK_HZ         20000000
`define IRC_BEEP_TIME_MS   100
`define IRC_BEEP_CYCLES    ((`IRC_CLK_HZ / 1000) * `IRC_BEEP_TIME_MS)
`define IRC_SEC_CYCLES     `IRC_CLK_HZ
`define IRC_TEXT_WORDS     8

`endif

/* File: rtl/irc_text_mem.v */
// Small message store for the front-panel text, registered read port
`timescale 1ns/100ps
module irc_text_mem
(
  // Clock
  input  wire        ref_clk,
  // Write port
  input  wire        wr_en,
  input  wire [2:0]  wr_addr,
  input  wire [31:0] wr_data,
  // Read port
  input  wire [2:0]  rd_addr,
  output reg  [31:0] rd_data
);

  reg [31:0] mem [0:7];

  // Write and registered read; no reset so it maps to RAM
  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: tb/irc_remote_ctrl_checker.sv */
// Port-level assertions for the remote-control block
`timescale 1ns/100ps
`include "irc_defines.vh"
module irc_remote_ctrl_checker
#(
  parameter [15:0] CAL_PASSWORD = 16'h1234,
  parameter [31:0] BEEP_CYCLES  = 32'h3
)
(
  // Clock and reset
  input wire        ref_clk,
  input wire        resetn,
  // Bus
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  // Panel
  input wire        knobs_enable,
  input wire        local_key_enable,
  input wire        display_on,
  input wire        annunciators_enable,
  input wire        error_annunciator_enable,
  input wire [2:0]  panel_brightness,
  input wire        beeper_out,
  // Trigger and calibration
  input wire        output_update,
  input wire        cal_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg  [31:0] beep_cnt_r;
  reg         src_bus_r;
  wire        cmd_wr = wb_ack_o && wb_stb_i && wb_we_i && wb_adr_i == `IRC_OFS_COMMAND;
  wire [3:0]  code   = wb_dat_i[3:0];
  // Beep length counter; source bit mirrored so trigger timing can be judged
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      beep_cnt_r <= 32'h0;
      src_bus_r  <= 1'b0;
    end
    else
    begin
      beep_cnt_r <= beeper_out ? beep_cnt_r + 32'h1 : 32'h0;
      if (wb_ack_o && wb_stb_i && wb_we_i && wb_adr_i == `IRC_OFS_CONTROL)
        src_bus_r <= wb_dat_i[`IRC_CTL_SRC_BUS];
    end
  end
  // Accepted command steps
  sequence s_arm_imm;
    cmd_wr && code == `IRC_CMD_ARM && !src_bus_r;
  endsequence
  sequence s_pass_ok;
    cmd_wr && code == `IRC_CMD_CAL_PASS && wb_dat_i[31:16] == CAL_PASSWORD;
  endsequence
  sequence s_cal_leave;
    cmd_wr && (code == `IRC_CMD_CAL_SAVE || code == `IRC_CMD_CAL_END);
  endsequence
  a_beep_len: assert property ($fell(beeper_out) |-> beep_cnt_r == BEEP_CYCLES)
    else $error("beep length wrong");
  a_local_mode: assert property (cmd_wr && code == `IRC_CMD_LOCAL |-> ##[0:1] knobs_enable && display_on)
    else $error("local command not honoured");
  a_remote_mode: assert property (cmd_wr && code == `IRC_CMD_REMOTE |-> ##[0:1] !knobs_enable && local_key_enable)
    else $error("remote command not honoured");
  a_lockout_mode: assert property (cmd_wr && code == `IRC_CMD_LOCKOUT |-> ##[0:1] !knobs_enable && !local_key_enable)
    else $error("lockout command not honoured");
  a_blank_annun: assert property (!display_on |-> !annunciators_enable && error_annunciator_enable)
    else $error("annunciators shown while blank");
  a_bright_range: assert property (panel_brightness <= `IRC_BRIGHT_MAX)
    else $error("brightness beyond top level");
  a_imm_trigger: assert property (s_arm_imm |-> output_update)
    else $error("immediate trigger late");
  a_cal_entry: assert property ($rose(cal_mode) |-> s_pass_ok)
    else $error("calibration entered without password");
  a_cal_exit: assert property ($fell(cal_mode) |-> s_cal_leave)
    else $error("calibration left without save or end");
endmodule
bind irc_remote_ctrl irc_remote_ctrl_checker #(.CAL_PASSWORD(CAL_PASSWORD), .BEEP_CYCLES(BEEP_CYCLES)) chk_u
(
  .ref_clk(ref_clk), .resetn(resetn), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .knobs_enable(knobs_enable), .local_key_enable(local_key_enable),
  .display_on(display_on), .annunciators_enable(annunciators_enable),
  .error_annunciator_enable(error_annunciator_enable), .panel_brightness(panel_brightness),
  .beeper_out(beeper_out), .output_update(output_update), .cal_mode(cal_mode)
);

/* File: tb/irc_ctl_model.sv */
// Controller model: bus master, trigger, local key and status lines
`timescale 1ns/100ps
module irc_ctl_model
(
  // Clock and bus answer
  input  wire        ref_clk,
  input  wire        ack,
  input  wire [31:0] rdat,
  // Bus request
  output reg         cyc = 1'b0,
  output reg         stb = 1'b0,
  output reg         we = 1'b0,
  output reg  [7:0]  adr = 8'h00,
  output reg  [3:0]  sel = 4'h0,
  output reg  [31:0] dat = 32'h0,
  // Events and status
  output reg         bus_get = 1'b0,
  output reg         key = 1'b0,
  output reg  [7:0]  sts = 8'h00
);
  integer n_late = 0;
  // Classic cycle; released data turns to its inverse so a stale word never matches
  task xfer(input bit w, input [7:0] a, input [31:0] d, output [31:0] q);
    int i;
  begin
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (ack !== 1'b1 && i < 50);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    dat <= ~d;
    if (i >= 50)
      n_late++;
  end
  endtask
  // One-cycle trigger or key pulse
  task ev(input bit k);
  begin
    @(posedge ref_clk);
    {bus_get, key} <= k ? 2'b01 : 2'b10;
    @(posedge ref_clk);
    {bus_get, key} <= 2'b00;
  end
  endtask
  task set_sts(input [7:0] v);
  begin
    @(posedge ref_clk);
    sts <= v;
  end
  endtask
endmodule

/* File: tb/irc_remote_ctrl_test.sv */
// Self-checking bench for the remote-control block
`timescale 1ns/100ps
`include "irc_defines.vh"
module irc_remote_ctrl_test;
  reg         ref_clk;
  reg         resetn = 1'b0;
  wire        cyc, stb, we, ack, get, key, kn, lk, dsp, ann, ean, beep, upd, calm, pstb, prot, store, srq;
  wire [7:0]  adr, sts;
  wire [3:0]  sel;
  wire [31:0] wd, rd_d, lvl, cpv;
  wire [2:0]  bri;
  wire [1:0]  ctype, cpi;
  reg  [31:0] q;
  integer     err_count = 0, n_compared = 0, n_upd = 0, n_pt = 0, n_prot = 0, n_st = 0, n_beep = 0, i;
  irc_remote_ctrl #(.SEC_CYCLES(32'h4), .BEEP_CYCLES(32'h3)) dut_u
  (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd_d), .wb_ack_o(ack), .bus_get_i(get), .local_key_i(key),
    .status_bits_i(sts), .knobs_enable(kn), .local_key_enable(lk), .display_on(dsp), .annunciators_enable(ann),
    .error_annunciator_enable(ean), .panel_brightness(bri), .beeper_out(beep), .output_update(upd),
    .output_level(lvl), .cal_mode(calm), .cal_type(ctype), .cal_point_strobe(pstb), .cal_point_index(cpi),
    .cal_point_value(cpv), .cal_prot_strobe(prot), .cal_store(store), .service_request(srq)
  );
  irc_ctl_model ctl_u
  (
    .ref_clk(ref_clk), .ack(ack), .rdat(rd_d), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wd), .bus_get(get), .key(key), .sts(sts)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Pulse counters, so no check hinges on catching a one-cycle strobe; idle in reset so no unknown gets in
  always @(posedge ref_clk)
  begin
    if (resetn)
    begin
      n_upd  <= n_upd + upd;
      n_pt   <= n_pt + pstb;
      n_prot <= n_prot + prot;
      n_st   <= n_st + store;
      n_beep <= n_beep + beep;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // Accesses end at the falling edge, after registered effects have landed
  task w(input [7:0] a, input [31:0] d);
  begin
    ctl_u.xfer(1'b1, a, d, q);
    @(negedge ref_clk);
  end
  endtask
  task r(input [7:0] a);
  begin
    ctl_u.xfer(1'b0, a, 32'h0, q);
    @(negedge ref_clk);
  end
  endtask
  task c(input [3:0] code, input [15:0] arg);
    w(`IRC_OFS_COMMAND, {arg, 12'h0, code});
  endtask
  task final_report;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #2000000;
    err_count++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("reset panel", {kn, lk, dsp, ann, ean, bri, beep, calm, srq}, {5'h1F, 3'h4, 3'h0});
    r(`IRC_OFS_VERSION);
    chk("version", q, {`IRC_VERSION_YEAR, `IRC_VERSION_FRAC});
    w(`IRC_OFS_CONTROL, 32'h43);
    r(`IRC_OFS_CONTROL);
    chk("beeper setting", q, 32'h43);
    c(`IRC_CMD_BEEP, 16'h0);
    repeat (8) @(negedge ref_clk);
    chk("beep cycles", n_beep, 3);
    // Level 5 is out of range and must leave level 4 in place
    for (i = 0; i < 6; i++)
    begin
      w(`IRC_OFS_CONTROL, {25'h0, i[2:0], 4'h2});
      chk("brightness", bri, (i > 4) ? 4 : i);
    end
    w(`IRC_OFS_CONTROL, 32'h40);
    chk("blank", {dsp, ann, ean}, 3'b001);
    c(`IRC_CMD_REMOTE, 16'h0);
    chk("remote", {kn, lk, dsp}, 3'b010);
    ctl_u.ev(1'b1);
    r(8'h80);
    chk("unmapped", q, 0);
    chk("key to local", {kn, dsp}, 2'b11);
    c(`IRC_CMD_LOCKOUT, 16'h0);
    ctl_u.ev(1'b1);
    r(8'h80);
    chk("lockout", {kn, lk}, 2'b00);
    w(`IRC_OFS_CONTROL, 32'h40);
    c(`IRC_CMD_LOCAL, 16'h0);
    chk("local", {kn, lk, dsp}, 3'b111);
    // Trigger: clamp, immediate ignores delay, bus source waits
    w(`IRC_OFS_TRIG_DELAY, 32'd5000);
    r(`IRC_OFS_TRIG_DELAY);
    chk("delay clamp", q, 3600);
    w(`IRC_OFS_TRIG_DELAY, 32'h2);
    w(`IRC_OFS_TRIG_LEVEL, 32'h55);
    c(`IRC_CMD_ARM, 16'h0);
    r(`IRC_OFS_CONTROL);
    chk("immediate", n_upd, 1);
    chk("source imm", q[2], 0);
    chk("level", lvl, 32'h55);
    w(`IRC_OFS_CONTROL, 32'h46);
    r(`IRC_OFS_CONTROL);
    chk("source bus", q[2], 1);
    c(`IRC_CMD_ARM, 16'h0);
    repeat (20) @(negedge ref_clk);
    chk("armed idle", n_upd, 1);
    c(`IRC_CMD_TRG, 16'h0);
    for (i = 0; i < 40 && n_upd == 1; i++)
      @(negedge ref_clk);
    chk("bus delay", i >= 8 && i <= 12, 1);
    w(`IRC_OFS_TRIG_DELAY, 32'h0);
    c(`IRC_CMD_ARM, 16'h0);
    ctl_u.ev(1'b0);
    for (i = 0; i < 40 && n_upd == 2; i++)
      @(negedge ref_clk);
    chk("bus get", i < 4, 1);
    // Calibration sequencer
    c(`IRC_CMD_CAL_PASS, 16'h1111);
    chk("bad password", calm, 0);
    c(`IRC_CMD_CAL_PASS, 16'h1234);
    chk("cal entry", calm, 1);
    for (i = 0; i < 2; i++)
    begin
      c(`IRC_CMD_CAL_TYPE, i[0] ? 16'h2 : 16'h0);
      w(`IRC_OFS_CAL_VALUE, 32'h100 + i);
      c(`IRC_CMD_CAL_MIN, 16'h0);
      chk("point index min", cpi, 0);
      c(`IRC_CMD_CAL_MID, 16'h0);
      c(`IRC_CMD_CAL_MAX, 16'h0);
      chk("point index max", cpi, 2);
      chk("point value", cpv, 32'h100 + i);
      chk("auto type", ctype, i[0] ? 3 : 1);
      c(`IRC_CMD_CAL_PROT, 16'h0);
    end
    c(`IRC_CMD_CAL_TYPE, 16'h0);
    chk("retype", ctype, 0);
    c(`IRC_CMD_CAL_END, 16'h0);
    r(8'h80);
    chk("cal strobes", {calm, n_st[3:0], n_pt[3:0], n_prot[3:0]}, 13'h0062);
    c(`IRC_CMD_CAL_PASS, 16'h1234);
    c(`IRC_CMD_CAL_SAVE, 16'h0);
    r(8'h80);
    chk("cal save", {calm, n_st[3:0]}, 5'h01);
    // Message text and clear
    w(`IRC_OFS_TEXT_BASE, 32'h41424344);
    r(`IRC_OFS_TEXT_BASE);
    chk("text", q, 32'h41424344);
    c(`IRC_CMD_TEXT_CLR, 16'h0);
    r(`IRC_OFS_TEXT_BASE);
    chk("text cleared", q, 0);
    // Service request only once both masks pass the bit
    ctl_u.set_sts(8'h01);
    w(`IRC_OFS_SRQ_EN, 32'h1);
    r(`IRC_OFS_STATUS);
    chk("srq masked", srq, 0);
    chk("status bits", q[15:8], 8'h01);
    w(`IRC_OFS_STAT_EN, 32'h1);
    r(8'h80);
    chk("srq", srq, 1);
    chk("bus timeouts", ctl_u.n_late, 0);
    final_report;
  end
endmodule
